/* File: hdl/timer16_pkg.sv */
// Package of constants and types for the 16-bit compare timer.
`default_nettype none
package timer16_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL_A = 4'h0;
  localparam logic [3:0] OFF_CONTROL_B = 4'h1;
  localparam logic [3:0] OFF_CONTROL_C = 4'h2;
  localparam logic [3:0] OFF_COUNTER   = 4'h3;
  localparam logic [3:0] OFF_COMPARE_A = 4'h4;
  localparam logic [3:0] OFF_COMPARE_B = 4'h5;
  localparam logic [3:0] OFF_CAPTURE   = 4'h6;
  localparam logic [3:0] OFF_FLAGS     = 4'h7;
  localparam logic [3:0] OFF_PORT      = 4'h8;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACT_A_LSB  = 6;
  localparam int ACT_B_LSB  = 4;
  localparam int WGM_LO_LSB = 0;
  localparam int WGM_HI_LSB = 3;
  localparam int CS_LSB     = 0;
  localparam int FOC_A_BIT  = 7;
  localparam int FOC_B_BIT  = 6;
  localparam int FLAG_OVF   = 0;
  localparam int FLAG_CMPA  = 1;
  localparam int FLAG_CMPB  = 2;
  localparam int FLAG_CAP   = 5;
  localparam int PORT_DIR_A = 0;
  localparam int PORT_DIR_B = 1;
  localparam int PORT_OUT_A = 2;
  localparam int PORT_OUT_B = 3;
  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [3:0]  WGM_NORMAL = 4'h0;
  localparam logic [3:0]  WGM_CTC_A  = 4'h4;
  localparam logic [3:0]  WGM_CTC_I  = 4'hC;
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [1:0]  ACT_SET    = 2'h3;
  localparam logic [9:0]  DIV_8      = 10'h007;
  localparam logic [9:0]  DIV_64     = 10'h03F;
  localparam logic [9:0]  DIV_256    = 10'h0FF;
  localparam logic [9:0]  DIV_1024   = 10'h3FF;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;
  typedef struct packed {
    logic dir_a;
    logic dir_b;
    logic port_a;
    logic port_b;
  } port_cfg_t;
endpackage : timer16_pkg
`default_nettype wire

/* File: hdl/timer16_compare_output.sv */
// Timer core with normal and clear-on-match counting and compare outputs.
// How it works
// R1 - Reset clears both compare-output state bits to zero.
// R2 - Nonzero action field swaps port output value for compare-output state.
// R3 - Direction bit alone enables the pin driver, also during override.
// R4 - Force strobe may preload the state while the pin driver is still off.
// R5 - Reserved action codes in unsupported modes perform no waveform action.
// R6 - Action field never touches capture logic.
// R7 - Action zero leaves the state unchanged on match.
// R8 - New action field value acts only at the next compare match.
// R9 - Force strobe in non-PWM modes applies the action at once.
// R10 - Count sequence depends on the waveform mode field; clock select sets the tick rate and stops counting at 0.
// R11 - Non-PWM actions toggle, clear or set; in other modes every code holds the state.
// R12 - Mode 0x0 counts up only and wraps 0xFFFF to 0x0000.
// R13 - Overflow flag sets when the counter passes 0xFFFF; acknowledge or a flag write clears it.
// R14 - Overflow flag clears on interrupt acknowledge.
// R15 - Counter writes are accepted at any time in normal mode.
// R16 - Clear-on-match resets at top: compare A for 0x4, capture for 0xC.
// R17 - Reaching top raises compare A flag or capture flag accordingly.
// R18 - Top is not buffered; a low top makes counter wrap first.
// R19 - Action 0x1 on channel A toggles the state on every match.
// R20 - Toggle period is 2 times N times one plus compare A clocks.
// R21 - Overflow flag sets when counter passes maximum to 0x0000.
// R22 - Compare flag sets on the timer tick after the match; compare A in mode 0x4 already sets at the match.
// R23 - Forced compare changes only the state, not flags or counter.
// R24 - A counter write blocks matches on the next timer tick.
// R25 - Action 0x2 clears and 0x3 sets the state on match.
// R26 - Matching compares all sixteen counter bits every timer tick.
`default_nettype none
module timer16_compare_output (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Interrupt acknowledges
  input  wire logic        overflow_ack,
  input  wire logic        compare_a_ack,
  input  wire logic        compare_b_ack,
  input  wire logic        capture_ack,
  // Capture event
  input  wire logic        capture_event,
  // Pins
  output logic             pin_a_out,
  output logic             pin_a_oe,
  output logic             pin_b_out,
  output logic             pin_b_oe
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  timer16_pkg::bus_req_t  req;
  timer16_pkg::port_cfg_t port_reg;
  logic [7:0]  timer_control_a_reg;
  logic [7:0]  timer_control_b_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] compare_value_a_reg;
  logic [15:0] compare_value_b_reg;
  logic [15:0] capture_value_reg;
  logic        overflow_flag_reg;
  logic        compare_a_flag_reg;
  logic        compare_b_flag_reg;
  logic        capture_flag_reg;
  logic        compare_output_state_a_reg;
  logic        compare_output_state_b_reg;
  logic        match_a_pend_reg;
  logic        match_b_pend_reg;
  logic        block_reg;
  logic [9:0]  presc_reg;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  logic [3:0] waveform_mode_select;
  logic [1:0] compare_output_action_a;
  logic [1:0] compare_output_action_b;
  logic [2:0] clock_select;
  assign waveform_mode_select = {timer_control_b_reg[timer16_pkg::WGM_HI_LSB +: 2],
                                 timer_control_a_reg[timer16_pkg::WGM_LO_LSB +: 2]};
  assign compare_output_action_a = timer_control_a_reg[timer16_pkg::ACT_A_LSB +: 2];
  assign compare_output_action_b = timer_control_a_reg[timer16_pkg::ACT_B_LSB +: 2];
  assign clock_select = timer_control_b_reg[timer16_pkg::CS_LSB +: 3];

  // Write strobes.
  logic wr_ctl_a, wr_ctl_b, wr_ctl_c, wr_cnt, wr_cmp_a, wr_cmp_b, wr_cap, wr_flags, wr_port;
  assign wr_ctl_a = req.wr && req.addr == timer16_pkg::OFF_CONTROL_A;
  assign wr_ctl_b = req.wr && req.addr == timer16_pkg::OFF_CONTROL_B;
  assign wr_ctl_c = req.wr && req.addr == timer16_pkg::OFF_CONTROL_C;
  assign wr_cnt   = req.wr && req.addr == timer16_pkg::OFF_COUNTER;
  assign wr_cmp_a = req.wr && req.addr == timer16_pkg::OFF_COMPARE_A;
  assign wr_cmp_b = req.wr && req.addr == timer16_pkg::OFF_COMPARE_B;
  assign wr_cap   = req.wr && req.addr == timer16_pkg::OFF_CAPTURE;
  assign wr_flags = req.wr && req.addr == timer16_pkg::OFF_FLAGS;
  assign wr_port  = req.wr && req.addr == timer16_pkg::OFF_PORT;

  // ----------------------------------------------------------------------
  // Mode decode and helpers
  // ----------------------------------------------------------------------
  logic mode_normal, mode_ctc_a, mode_ctc_i, mode_non_pwm;
  assign mode_normal  = waveform_mode_select == timer16_pkg::WGM_NORMAL;
  assign mode_ctc_a   = waveform_mode_select == timer16_pkg::WGM_CTC_A;
  assign mode_ctc_i   = waveform_mode_select == timer16_pkg::WGM_CTC_I;
  assign mode_non_pwm = mode_normal || mode_ctc_a || mode_ctc_i;

  // Next output state for an action; PWM waveforms are not built here, so
  // in the other modes every code holds the state.
  function automatic logic apply_action(input logic [1:0] act, input logic cur,
                                        input logic non_pwm);
    logic res;
    res = cur; // R5 R7
    if (non_pwm && act == timer16_pkg::ACT_TOGGLE) begin
      res = !cur; // R19 R11
    end else if (non_pwm && act == timer16_pkg::ACT_CLEAR) begin
      res = 1'b0; // R25
    end else if (non_pwm && act == timer16_pkg::ACT_SET) begin
      res = 1'b1; // R25
    end
    return res;
  endfunction : apply_action

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // The divider runs only while a divided clock is selected, so the first
  // tick after start lands a full period later.
  logic [9:0] div_limit;
  logic       running;
  logic       tick;
  always_comb begin
    div_limit = 10'h000;
    if (clock_select == 3'h2) begin
      div_limit = timer16_pkg::DIV_8;
    end else if (clock_select == 3'h3) begin
      div_limit = timer16_pkg::DIV_64;
    end else if (clock_select == 3'h4) begin
      div_limit = timer16_pkg::DIV_256;
    end else if (clock_select == 3'h5) begin
      div_limit = timer16_pkg::DIV_1024;
    end
  end
  assign running = clock_select != 3'h0 && clock_select <= 3'h5;
  assign tick    = running && presc_reg >= div_limit; // R20

  always_ff @(posedge clock) begin
    if (sys_rst || !running || tick) begin
      presc_reg <= 10'h000;
    end else begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [15:0] top_value;
  logic        match_a, match_b, at_top, ctc_mode;
  assign ctc_mode  = mode_ctc_a || mode_ctc_i;
  assign top_value = mode_ctc_i ? capture_value_reg : compare_value_a_reg; // R16
  assign match_a   = tick && !block_reg && counter_value_reg == compare_value_a_reg; // R26 R24
  assign match_b   = tick && !block_reg && counter_value_reg == compare_value_b_reg; // R26 R24
  assign at_top    = tick && !block_reg && ctc_mode && counter_value_reg == top_value; // R18

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      counter_value_reg <= timer16_pkg::COUNT_ZERO;
    end else if (wr_cnt) begin
      counter_value_reg <= req.wdata; // R15
    end else if (at_top) begin
      counter_value_reg <= timer16_pkg::COUNT_ZERO; // R16 R10
    end else if (tick) begin
      counter_value_reg <= counter_value_reg + 16'h0001; // R12 R18
    end
  end

  // A counter write masks matches until the next timer tick has passed.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      block_reg <= 1'b0;
    end else if (wr_cnt) begin
      block_reg <= 1'b1; // R24
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      timer_control_a_reg <= 8'h00;
      timer_control_b_reg <= 8'h00;
      compare_value_a_reg <= timer16_pkg::COUNT_ZERO;
      compare_value_b_reg <= timer16_pkg::COUNT_ZERO;
      port_reg            <= '0;
    end else begin
      if (wr_ctl_a) begin
        timer_control_a_reg <= req.wdata[7:0];
      end
      if (wr_ctl_b) begin
        timer_control_b_reg <= req.wdata[7:0];
      end
      if (wr_cmp_a) begin
        compare_value_a_reg <= req.wdata; // R18
      end
      if (wr_cmp_b) begin
        compare_value_b_reg <= req.wdata;
      end
      if (wr_port) begin
        port_reg.dir_a  <= req.wdata[timer16_pkg::PORT_DIR_A];
        port_reg.dir_b  <= req.wdata[timer16_pkg::PORT_DIR_B];
        port_reg.port_a <= req.wdata[timer16_pkg::PORT_OUT_A];
        port_reg.port_b <= req.wdata[timer16_pkg::PORT_OUT_B];
      end
    end
  end

  // Capture register: software write or capture event, action field unused.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      capture_value_reg <= timer16_pkg::COUNT_ZERO;
    end else if (wr_cap) begin
      capture_value_reg <= req.wdata;
    end else if (capture_event && !mode_ctc_i) begin
      capture_value_reg <= counter_value_reg; // R6
    end
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  // Compare flags set one timer tick after the match (compare A in mode 0x4 already at the match); a pending bit holds it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      match_a_pend_reg <= 1'b0;
      match_b_pend_reg <= 1'b0;
    end else if (tick) begin
      match_a_pend_reg <= match_a; // R22
      match_b_pend_reg <= match_b; // R22
    end
  end

  logic ovf_set, cmpa_set, cmpb_set, cap_set;
  assign ovf_set  = tick && counter_value_reg == timer16_pkg::COUNT_MAX; // R13 R21
  assign cmpa_set = (tick && match_a_pend_reg) || (at_top && mode_ctc_a); // R22 R17
  assign cmpb_set = tick && match_b_pend_reg; // R22
  assign cap_set  = (capture_event && !mode_ctc_i) || (at_top && mode_ctc_i); // R17

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      overflow_flag_reg  <= 1'b0;
      compare_a_flag_reg <= 1'b0;
      compare_b_flag_reg <= 1'b0;
      capture_flag_reg   <= 1'b0;
    end else begin
      if (ovf_set) begin
        overflow_flag_reg <= 1'b1; // R13
      end else if (overflow_ack || (wr_flags && req.wdata[timer16_pkg::FLAG_OVF])) begin
        overflow_flag_reg <= 1'b0; // R14
      end
      if (cmpa_set) begin
        compare_a_flag_reg <= 1'b1;
      end else if (compare_a_ack || (wr_flags && req.wdata[timer16_pkg::FLAG_CMPA])) begin
        compare_a_flag_reg <= 1'b0;
      end
      if (cmpb_set) begin
        compare_b_flag_reg <= 1'b1;
      end else if (compare_b_ack || (wr_flags && req.wdata[timer16_pkg::FLAG_CMPB])) begin
        compare_b_flag_reg <= 1'b0;
      end
      if (cap_set) begin
        capture_flag_reg <= 1'b1;
      end else if (capture_ack || (wr_flags && req.wdata[timer16_pkg::FLAG_CAP])) begin
        capture_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Compare-output state
  // ----------------------------------------------------------------------
  // The action field is read live at the match, so a new value first acts
  // on the next match after the write.
  logic force_a, force_b;
  assign force_a = wr_ctl_c && req.wdata[timer16_pkg::FOC_A_BIT] && mode_non_pwm; // R9
  assign force_b = wr_ctl_c && req.wdata[timer16_pkg::FOC_B_BIT] && mode_non_pwm; // R9

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      compare_output_state_a_reg <= 1'b0; // R1
      compare_output_state_b_reg <= 1'b0; // R1
    end else begin
      if (match_a || force_a) begin
        compare_output_state_a_reg <= apply_action(compare_output_action_a,
          compare_output_state_a_reg, mode_non_pwm); // R8 R23 R4
      end
      if (match_b || force_b) begin
        compare_output_state_b_reg <= apply_action(compare_output_action_b,
          compare_output_state_b_reg, mode_non_pwm); // R8 R23
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------------
  assign pin_a_out = (compare_output_action_a != timer16_pkg::ACT_NONE) ?
                     compare_output_state_a_reg : port_reg.port_a; // R2
  assign pin_b_out = (compare_output_action_b != timer16_pkg::ACT_NONE) ?
                     compare_output_state_b_reg : port_reg.port_b; // R2
  assign pin_a_oe  = port_reg.dir_a; // R3
  assign pin_b_oe  = port_reg.dir_b; // R3

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (!req.rd) begin
      reg_rdata <= 16'h0000;
    end else if (req.addr == timer16_pkg::OFF_CONTROL_A) begin
      reg_rdata <= {8'h00, timer_control_a_reg};
    end else if (req.addr == timer16_pkg::OFF_CONTROL_B) begin
      reg_rdata <= {8'h00, timer_control_b_reg};
    end else if (req.addr == timer16_pkg::OFF_COUNTER) begin
      reg_rdata <= counter_value_reg;
    end else if (req.addr == timer16_pkg::OFF_COMPARE_A) begin
      reg_rdata <= compare_value_a_reg;
    end else if (req.addr == timer16_pkg::OFF_COMPARE_B) begin
      reg_rdata <= compare_value_b_reg;
    end else if (req.addr == timer16_pkg::OFF_CAPTURE) begin
      reg_rdata <= capture_value_reg;
    end else if (req.addr == timer16_pkg::OFF_FLAGS) begin
      reg_rdata <= {10'h000, capture_flag_reg, 2'h0, compare_b_flag_reg,
                    compare_a_flag_reg, overflow_flag_reg};
    end else if (req.addr == timer16_pkg::OFF_PORT) begin
      reg_rdata <= {10'h000, compare_output_state_b_reg, compare_output_state_a_reg,
                    port_reg.port_b, port_reg.port_a, port_reg.dir_b, port_reg.dir_a};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_reset_state;
    @(posedge clock) sys_rst |=> !compare_output_state_a_reg && !compare_output_state_b_reg;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state not cleared"); // R1
  property p_override;
    @(posedge clock) disable iff (sys_rst)
      compare_output_action_a != 2'h0 |-> pin_a_out == compare_output_state_a_reg;
  endproperty
  a_override: assert property (p_override) else $error("override missing"); // R2
  property p_wrap;
    @(posedge clock) disable iff (sys_rst)
      tick && mode_normal && !wr_cnt && counter_value_reg == 16'hFFFF
      |=> counter_value_reg == 16'h0000 && overflow_flag_reg;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong"); // R12
  property p_ctc_clear;
    @(posedge clock) disable iff (sys_rst)
      at_top && !wr_cnt |=> counter_value_reg == 16'h0000;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("no clear at top"); // R16
  property p_toggle;
    @(posedge clock) disable iff (sys_rst)
      match_a && mode_ctc_a && compare_output_action_a == 2'h1
      |=> compare_output_state_a_reg != $past(compare_output_state_a_reg);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle"); // R19
  property p_block;
    @(posedge clock) disable iff (sys_rst)
      wr_cnt |=> !match_a && !match_b;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked"); // R24
  property p_force_no_flag;
    @(posedge clock) disable iff (sys_rst)
      force_a && !tick |=> $stable(compare_a_flag_reg) || !compare_a_flag_reg;
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag"); // R23
  // The pending bit carries a match to the next tick, however many clocks that takes.
  property p_flag_delay;
    @(posedge clock) disable iff (sys_rst) tick && match_a_pend_reg |=> compare_a_flag_reg;
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("late flag"); // R22
  property p_action_zero;
    @(posedge clock) disable iff (sys_rst)
      match_b && compare_output_action_b == 2'h0 |=> $stable(compare_output_state_b_reg);
  endproperty
  a_action_zero: assert property (p_action_zero) else $error("state moved"); // R7
endmodule : timer16_compare_output
`default_nettype wire

/* File: sim/timer16_compare_output_bench.sv */
// Self-checking bench for the compare-output timer core.
`default_nettype none
module timer16_compare_output_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        sys_rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        capture_event;
  logic [3:0]  reg_addr;
  logic [3:0]  acks;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic [15:0] st;
  logic        pin_a_out;
  logic        pin_a_oe;
  logic        pin_b_out;
  logic        pin_b_oe;
  logic        last;
  int          failures;
  int          n_checks;
  int          cycles;
  int          k;
  logic [15:0] ocr;
  logic [1:0]  act;

  timer16_compare_output dut_u (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .overflow_ack(acks[0]),
    .compare_a_ack(acks[1]), .compare_b_ack(acks[2]), .capture_ack(acks[3]),
    .capture_event(capture_event), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));

  // ----------------------------------------------------------------------
  // Expectation functions
  // ----------------------------------------------------------------------
  function automatic logic [15:0] next_state(input logic [1:0] a, input logic [15:0] s);
    case (a)
      timer16_pkg::ACT_TOGGLE: return s ^ 16'h0010;
      timer16_pkg::ACT_CLEAR:  return 16'h0000;
      timer16_pkg::ACT_SET:    return 16'h0010;
      default:                 return s;
    endcase
  endfunction : next_state

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
    chk(rd_val & m, exp);
  endtask : rchk

  task automatic pulse(input int i);
    @(posedge clock);
    acks <= 4'h1 << i;
    @(posedge clock);
    acks <= 4'h0;
  endtask : pulse

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, capture_event, reg_addr, acks, reg_wdata} = '0;
    sys_rst = 1'b1;
    k = $urandom(22);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(4'h8, 16'hFFFF, 16'h0000);
    chk({14'h0, pin_a_out, pin_a_oe}, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rchk(4'hF, 16'hFFFF, 16'h0000);
    $display("reset test done");
    // Preload the state with the pin still an input, then enable the driver.
    wr(4'h0, {8'h0, timer16_pkg::ACT_SET, 6'h0});
    wr(4'h2, 16'h0080);
    rchk(4'h8, 16'h0010, 16'h0010);
    chk({15'h0, pin_a_oe}, 16'h0000);
    wr(4'h8, 16'h0001);
    chk({15'h0, pin_a_out}, 16'h0001);
    wr(4'h0, 16'h0000);
    chk({14'h0, pin_a_out, pin_a_oe}, 16'h0001);
    wr(4'h8, 16'h0005);
    chk({14'h0, pin_a_out, pin_a_oe}, 16'h0003);
    wr(4'h8, 16'h000A);
    chk({14'h0, pin_b_out, pin_b_oe}, 16'h0003);
    $display("override test done");
    st = 16'h0010;
    wr(4'h7, 16'hFFFF);
    for (int i = 0; i < 10; i++) begin
      act = (i < 4) ? 2'(i) : 2'($urandom % 4);
      wr(4'h0, {8'h0, act, 6'h0});
      wr(4'h2, 16'h0080);
      st = next_state(act, st);
      rchk(4'h8, 16'h0010, st);
    end
    rchk(4'h7, 16'h0027, 16'h0000);
    rchk(4'h3, 16'hFFFF, 16'h0000);
    $display("force test done");
    wr(4'h3, 16'hFFFD);
    wr(4'h1, 16'h0001);
    repeat (6) @(posedge clock);
    wr(4'h1, 16'h0000);
    // Compare A still holds zero, so passing zero applied the last action once.
    st = next_state(act, st);
    rchk(4'h7, 16'h0001, 16'h0001);
    pulse(0);
    rchk(4'h7, 16'h0001, 16'h0000);
    $display("overflow test done");
    wr(4'h4, 16'h0010);
    wr(4'h0, {8'h0, timer16_pkg::ACT_TOGGLE, 6'h0});
    rchk(4'h8, 16'h0010, st);
    wr(4'h3, 16'h0010);
    wr(4'h7, 16'hFFFF);
    wr(4'h1, 16'h0001);
    repeat (3) @(posedge clock);
    wr(4'h1, 16'h0000);
    rchk(4'h8, 16'h0010, st);
    rchk(4'h7, 16'h0002, 16'h0000);
    $display("blocking test done");
    for (int cs = 1; cs <= 2; cs++) begin
      ocr = 16'(1 + $urandom % 6);
      wr(4'h3, 16'h0000);
      wr(4'h4, ocr);
      wr(4'h1, 16'(8 + cs));
      for (int h = 0; h < 2; h++) begin
        last = pin_a_out;
        k = 0;
        while (pin_a_out === last && k < 300) begin
          @(posedge clock);
          #1;
          k++;
        end
      end
      chk(16'(k), (cs == 1 ? 16'd1 : 16'd8) * (ocr + 16'd1));
      wr(4'h1, 16'h0000);
      rchk(4'h7, 16'h0002, 16'h0002);
      wr(4'h7, 16'hFFFF);
    end
    $display("clear on match test done");
    wr(4'h0, 16'h0000);
    wr(4'h6, 16'h0005);
    wr(4'h3, 16'h0000);
    wr(4'h1, 16'h0019);
    repeat (20) @(posedge clock);
    wr(4'h1, 16'h0000);
    rchk(4'h7, 16'h0020, 16'h0020);
    rchk(4'h3, 16'hFFF8, 16'h0000);
    chk({15'h0, rd_val <= 16'h0005}, 16'h0001);
    pulse(3);
    rchk(4'h7, 16'h0020, 16'h0000);
    wr(4'h0, 16'h00C0);
    wr(4'h3, 16'h0123);
    @(posedge clock);
    capture_event <= 1'b1;
    @(posedge clock);
    capture_event <= 1'b0;
    rchk(4'h6, 16'hFFFF, 16'h0123);
    rchk(4'h7, 16'h0020, 16'h0020);
    $display("capture top test done");
    end_of_test();
  end
endmodule : timer16_compare_output_bench
`default_nettype wire
